// ### bench/analog_front_model.sv
// Far side model: sense comparators, current ADC strobe and the series FET path.
// Assumes the bench changes its commands right after a rising clock edge.
`timescale 1ns/1ps
module analog_front_model (
    // Commands from the bench
    input wire logic clk,
    input wire logic [8:0] mvCmd,
    input wire logic [1:0] dirCmd,
    input wire logic convReq,
    input wire logic [13:0] rawCmd,
    // FET drive
    input wire logic chgFetOn,
    input wire logic disFetOn,
    // Towards the monitor
    output logic adcValid,
    output logic [13:0] adcRaw,
    output logic [8:0] senseMv,
    output logic outflow,
    output logic inflow
);
    logic [13:0] lastRaw_r = 14'h0000;
    logic pathOn;
    // Back-to-back FETs: pack current only flows with both on
    assign pathOn = chgFetOn & disFetOn;
    assign senseMv = pathOn ? mvCmd : 9'h000;
    assign outflow = pathOn & dirCmd[0];
    assign inflow = pathOn & dirCmd[1];
    assign adcValid = convReq;
    // Between strobes the data bus toggles, so the last word comes back only every other cycle
    assign adcRaw = convReq ? rawCmd : ~lastRaw_r;
    always_ff @(posedge clk)
    begin
        lastRaw_r <= adcRaw;
    end
endmodule

// ### bench/overcurrent_protect_monitor_bench.sv
// Self-checking bench of the overcurrent monitor over APB and the analog model.
// Assumes shortened time units: 2 cycles per us, 4 us per ms, 4 ms per s, 2 s per min.
`timescale 1ns/1ps
module overcurrent_protect_monitor_bench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, rerr, adcValid, outflow, inflow, chgFetOn, disFetOn, irq;
    logic [1:0] ampGain;
    logic [13:0] adcRaw;
    logic [8:0] senseMv;
    logic [8:0] mvCmd = 9'h000;
    logic [1:0] dirCmd = 2'h0;
    logic convReq = 1'b0;
    logic [13:0] rawCmd = 14'h0000;
    int fail_count = 0;
    int compares = 0;
    localparam logic [4:0] FLAGS [3] = '{5'h09, 5'h12, 5'h0c};

    initial
    begin
        forever #5 clk = ~clk;
    end

    overcurrent_protect_monitor #(.US_CYC(2), .MS_US(4), .S_MS(4), .MIN_S(2), .DIR_CYC(20))
    dut_u (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adcValid(adcValid), .adcRaw(adcRaw), .senseMv(senseMv),
        .outflow(outflow), .inflow(inflow), .ampGain(ampGain), .chgFetOn(chgFetOn),
        .disFetOn(disFetOn), .irq(irq));

    analog_front_model front_u (.clk(clk), .mvCmd(mvCmd), .dirCmd(dirCmd),
        .convReq(convReq), .rawCmd(rawCmd), .chgFetOn(chgFetOn), .disFetOn(disFetOn),
        .adcValid(adcValid), .adcRaw(adcRaw), .senseMv(senseMv), .outflow(outflow),
        .inflow(inflow));

    ////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task final_report;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Request held until the edge that sees pready; read data taken at that edge
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 20)
            check(32'h0, 32'h1, "no pready");
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task conv(input logic [13:0] r);
        @(posedge clk);
        rawCmd <= r;
        convReq <= 1'b1;
        @(posedge clk);
        convReq <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////
    task t_regs;
        check({ampGain, chgFetOn, disFetOn, irq}, 5'b00110, "outputs after reset");
        xfer(1'b0, 8'h30, 32'h0);
        check({31'h0, rerr}, 32'h1, "unmapped error");
        check(rdata, 32'h0, "unmapped read");
        for (int g = 0; g < 4; g++)
        begin
            xfer(1'b1, ocp_pkg::A_CTRL, g);
            repeat (2) @(negedge clk);
            check(ampGain, (g == 3) ? 0 : g, "gain select");
        end
        $display("regs test done");
    endtask

    task t_conv;
        xfer(1'b1, ocp_pkg::A_CAL, 32'h34);
        xfer(1'b1, ocp_pkg::A_ICLR, 32'h1f);
        // Idle mode keeps the monitor running
        xfer(1'b1, ocp_pkg::A_CTRL, 32'h20);
        conv(14'h1234);
        xfer(1'b0, ocp_pkg::A_CUR, 32'h0);
        check(rdata, {4'h0, 12'h480, 2'h0, 14'h1200}, "corrected result");
        check(irq, 1'b0, "masked interrupt");
        xfer(1'b1, ocp_pkg::A_IEN, 32'h8);
        repeat (2) @(negedge clk);
        check(irq, 1'b1, "enabled interrupt");
        xfer(1'b1, ocp_pkg::A_ICLR, 32'h1f);
        repeat (2) @(negedge clk);
        check(irq, 1'b0, "cleared interrupt");
        xfer(1'b1, ocp_pkg::A_DDIS, 32'h0);
        for (int m = 2; m < 4; m++)
        begin
            xfer(1'b1, ocp_pkg::A_CTRL, m << 5);
            mvCmd <= 9'h0c8;
            dirCmd <= 2'b01;
            conv(14'h0777);
            repeat (30) @(negedge clk);
            xfer(1'b0, ocp_pkg::A_CUR, 32'h0);
            check(rdata[13:0], 14'h1200, "no conversion when off");
            xfer(1'b0, ocp_pkg::A_STAT, 32'h0);
            check(rdata[6:0], 7'h00, "no fault or direction when off");
            mvCmd <= 9'h000;
            dirCmd <= 2'b00;
        end
        xfer(1'b1, ocp_pkg::A_CTRL, 32'h0);
        $display("conversion test done");
    endtask

    task t_dir;
        dirCmd <= 2'b01;
        repeat (15) @(posedge clk);
        dirCmd <= 2'b00;
        @(posedge clk);
        dirCmd <= 2'b01;
        repeat (15) @(posedge clk);
        xfer(1'b0, ocp_pkg::A_STAT, 32'h0);
        check(rdata[6:5], 2'b00, "interrupted outflow");
        repeat (10) @(posedge clk);
        xfer(1'b0, ocp_pkg::A_STAT, 32'h0);
        check(rdata[6:5], 2'b01, "discharge seen");
        dirCmd <= 2'b10;
        repeat (10) @(posedge clk);
        xfer(1'b0, ocp_pkg::A_STAT, 32'h0);
        check(rdata[6:5], 2'b01, "discharge still held");
        repeat (15) @(posedge clk);
        xfer(1'b0, ocp_pkg::A_STAT, 32'h0);
        check(rdata[6:5], 2'b10, "charge seen");
        dirCmd <= 2'b00;
        repeat (30) @(posedge clk);
        $display("direction test done");
    endtask

    task t_table;
        logic [8:0] mv;
        for (int t = 0; t < 3; t++)
        begin
            xfer(1'b1, ocp_pkg::A_DDIS, (t == 0) ? 32'h0 : 32'hfff);
            xfer(1'b1, ocp_pkg::A_DCHG, (t == 1) ? 32'h0 : 32'hfff);
            xfer(1'b1, ocp_pkg::A_DSHT, (t == 2) ? 32'h0 : 32'hfff);
            for (int c = 0; c < 8; c++)
            begin
                mv = (t == 0) ? ocp_pkg::DIS_MV[c] :
                    (t == 1) ? ocp_pkg::CHG_MV[c] : ocp_pkg::SC_MV[c];
                xfer(1'b1, ocp_pkg::A_THR, c << (3 * t));
                mvCmd <= mv;
                dirCmd <= (t == 1) ? 2'b10 : 2'b01;
                repeat (10) @(posedge clk);
                xfer(1'b0, ocp_pkg::A_STAT, 32'h0);
                check(rdata[4:0], 5'h00, "at threshold");
                mvCmd <= mv + 9'h001;
                repeat (10) @(negedge clk);
                check({chgFetOn, disFetOn}, 2'b00, "fets off");
                xfer(1'b0, ocp_pkg::A_STAT, 32'h0);
                check(rdata[4:0], FLAGS[t], "flags");
                xfer(1'b0, ocp_pkg::A_ISTAT, 32'h0);
                check(rdata[t], 1'b1, "trip event");
                mvCmd <= 9'h000;
                dirCmd <= 2'b00;
                xfer(1'b1, ocp_pkg::A_FCLR, 32'h1f);
                xfer(1'b1, ocp_pkg::A_ICLR, 32'h1f);
            end
        end
        $display("threshold test done");
    endtask

    task t_delay;
        int u, n;
        xfer(1'b1, ocp_pkg::A_THR, 32'h0);
        xfer(1'b1, ocp_pkg::A_DSHT, 32'hfff);
        for (int s = 0; s < 4; s++)
        begin
            u = (s == 0) ? 2 : (s == 1) ? 8 : (s == 2) ? 32 : 64;
            xfer(1'b1, ocp_pkg::A_DDIS, {s[1:0], 10'h003});
            mvCmd <= 9'h0ff;
            dirCmd <= 2'b01;
            // A one-cycle dip must restart the whole delay
            if (s == 1)
            begin
                repeat (2 * u) @(posedge clk);
                mvCmd <= 9'h000;
                @(posedge clk);
                mvCmd <= 9'h0ff;
            end
            n = 0;
            while (disFetOn === 1'b1 && n < 2000)
            begin
                @(negedge clk);
                n++;
            end
            check(n >= 3 * u && n <= 4 * u + 4, 1'b1, "trip delay");
            mvCmd <= 9'h000;
            dirCmd <= 2'b00;
            xfer(1'b1, ocp_pkg::A_FCLR, 32'h1f);
        end
        $display("delay test done");
    endtask

    task t_override;
        xfer(1'b1, ocp_pkg::A_CTRL, 32'h1c);
        xfer(1'b1, ocp_pkg::A_DDIS, 32'h0);
        mvCmd <= 9'h00a;
        dirCmd <= 2'b01;
        repeat (10) @(negedge clk);
        check({chgFetOn, disFetOn}, 2'b11, "override keeps fets");
        xfer(1'b0, ocp_pkg::A_STAT, 32'h0);
        check(rdata[0], 1'b1, "flag under override");
        xfer(1'b1, ocp_pkg::A_DSHT, 32'h0);
        mvCmd <= 9'h014;
        repeat (10) @(negedge clk);
        check({chgFetOn, disFetOn}, 2'b00, "short ignores override");
        mvCmd <= 9'h000;
        dirCmd <= 2'b00;
        xfer(1'b1, ocp_pkg::A_FCLR, 32'h1f);
        xfer(1'b1, ocp_pkg::A_CTRL, 32'h0c);
        repeat (2) @(negedge clk);
        check({chgFetOn, disFetOn}, 2'b10, "host drives fets");
        $display("override test done");
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        t_regs();
        t_conv();
        t_dir();
        t_table();
        t_delay();
        t_override();
        final_report();
    end

    // Whole run needs well under 10k cycles
    initial
    begin
        #500_000;
        fail_count++;
        final_report();
    end
endmodule

// ### src/ocp_pkg.sv
// Constants, register map and field layouts of the overcurrent monitor.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
package ocp_pkg;
    ////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int US_PER_S = 1_000_000;
    localparam int MS_PER_S = 1000;
    localparam int US_CYC = CLK_HZ / US_PER_S;
    localparam int MS_US = 1000;
    localparam int S_MS = 1000;
    localparam int MIN_S = 60;
    localparam int DIR_FILTER_MS = 2;
    localparam int DIR_CYC = CLK_HZ / MS_PER_S * DIR_FILTER_MS;

    ////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_THR = 8'h04;
    localparam logic [7:0] A_DDIS = 8'h08;
    localparam logic [7:0] A_DCHG = 8'h0c;
    localparam logic [7:0] A_DSHT = 8'h10;
    localparam logic [7:0] A_CAL = 8'h14;
    localparam logic [7:0] A_CUR = 8'h18;
    localparam logic [7:0] A_STAT = 8'h1c;
    localparam logic [7:0] A_FCLR = 8'h20;
    localparam logic [7:0] A_ISTAT = 8'h24;
    localparam logic [7:0] A_ICLR = 8'h28;
    localparam logic [7:0] A_IEN = 8'h2c;

    ////////////////////////////////////////////////////////////////////
    // Modes and codes
    typedef enum logic [1:0] {PWR_NORMAL, PWR_IDLE, PWR_SLEEP, PWR_DOWN} pwr_e;
    localparam logic [1:0] GAIN_X5 = 2'h0;
    localparam logic [1:0] GAIN_X50 = 2'h1;
    localparam logic [1:0] GAIN_X500 = 2'h2;
    localparam logic [1:0] GAIN_RSVD = 2'h3;

    ////////////////////////////////////////////////////////////////////
    // Field layouts
    typedef struct packed {
        pwr_e mode;
        logic hostDisFet;
        logic hostChgFet;
        logic hostFetOverride;
        logic [1:0] currentGainSel;
    } ctrl_s;
    typedef struct packed {
        logic [2:0] shortThresholdCode;
        logic [2:0] chgOcThresholdCode;
        logic [2:0] disOcThresholdCode;
    } thr_s;
    typedef struct packed {
        logic [1:0] scale;
        logic [9:0] count;
    } delay_s;
    typedef struct packed {
        logic chargerPresentFlag;
        logic loadPresentFlag;
        logic shortCircuitFlag;
        logic chgOvercurrentFlag;
        logic disOvercurrentFlag;
    } status_s;
    typedef struct packed {
        logic dirChange;
        logic convDone;
        logic shortTrip;
        logic chgTrip;
        logic disTrip;
    } event_s;
    localparam int CTRL_W = $bits(ctrl_s);
    localparam int THR_W = $bits(thr_s);
    localparam int DLY_W = $bits(delay_s);
    localparam int ST_W = $bits(status_s);
    localparam int EV_W = $bits(event_s);
    localparam int CAL_W = 14;
    localparam int CMP_W = 12;
    localparam int MV_W = 9;
    localparam int CMP_LSB = 2;

    ////////////////////////////////////////////////////////////////////
    // Threshold tables in mV, indexed by the 3-bit code
    localparam logic [8:0] DIS_MV [8] = '{9'h004, 9'h008, 9'h010, 9'h018,
                                          9'h020, 9'h030, 9'h040, 9'h060};
    localparam logic [8:0] CHG_MV [8] = '{9'h001, 9'h002, 9'h004, 9'h006,
                                          9'h008, 9'h00c, 9'h010, 9'h018};
    localparam logic [8:0] SC_MV [8] = '{9'h010, 9'h018, 9'h020, 9'h030,
                                         9'h040, 9'h060, 9'h080, 9'h100};
endpackage

// ### src/overcurrent_protect_monitor.sv
// Digital side of the pack current monitor: gain select, offset-corrected
// conversion store, direction filter, three timed fault detectors, FET drive.
// Assumes the analog front end delivers synchronous comparator levels and a
// sense magnitude in mV measured between senseHighInput and senseLowInput.
//
// Summary of operation
// RL1: Monitor off in sleep and power-down
// RL2: Gain field selects 5x, 50x, 500x
// RL3: Store 14-bit result and 12-bit compare value
// RL4: Offset correction uses calibration constant
// RL5: Direction filtered by 2 ms both ways
// RL6: Detected direction sets its status flag
// RL7: Discharge overcurrent code table 4..96 mV
// RL8: Charge overcurrent code table 1..24 mV
// RL9: Short-circuit code table 16..256 mV
// RL10: Faults declared after continuous programmed delay
// RL11: Scale picks us, ms, s, min
// RL12: Discharge overcurrent sets its flag and load
// RL13: Overcurrent drops FETs unless host override
// RL14: Charge overcurrent sets its flag and charger
// RL15: Short circuit sets its flag and load
// RL16: Short circuit always drops FETs
// RL17: Dropping below threshold restarts the delay
// RL18: Fault flags held until cleared externally
`timescale 1ns/1ps
module overcurrent_protect_monitor #(
    parameter int US_CYC = ocp_pkg::US_CYC,
    parameter int MS_US = ocp_pkg::MS_US,
    parameter int S_MS = ocp_pkg::S_MS,
    parameter int MIN_S = ocp_pkg::MIN_S,
    parameter int DIR_CYC = ocp_pkg::DIR_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // APB slave
    input wire logic [ocp_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog front end
    input wire logic adcValid,
    input wire logic [ocp_pkg::CAL_W-1:0] adcRaw,
    input wire logic [ocp_pkg::MV_W-1:0] senseMv,
    input wire logic outflow,
    input wire logic inflow,
    // Amplifier, FET drivers, interrupt
    output logic [1:0] ampGain,
    output logic chgFetOn,
    output logic disFetOn,
    output logic irq
);
    localparam int PW = $clog2(US_CYC + MS_US + S_MS + MIN_S + 1);
    localparam int DW = $clog2(DIR_CYC + 1);
    localparam logic [3:0][PW-1:0] PRE_LAST = {PW'(MIN_S - 1), PW'(S_MS - 1),
                                               PW'(MS_US - 1), PW'(US_CYC - 1)};
    localparam logic [DW-1:0] DIR_LAST = DW'(DIR_CYC);

    typedef struct packed {
        ocp_pkg::ctrl_s ctrl;
        ocp_pkg::thr_s thr;
        ocp_pkg::delay_s [2:0] dly;
        logic [ocp_pkg::CAL_W-1:0] cal;
        logic [ocp_pkg::CAL_W-1:0] cur;
        logic [ocp_pkg::CMP_W-1:0] cmp;
        ocp_pkg::status_s st;
        logic [1:0] dir;
        logic autoOff;
        logic fetC;
        logic fetD;
        logic [1:0] gain;
        ocp_pkg::event_s ist;
        ocp_pkg::event_s ien;
        logic irq;
        logic [3:0][PW-1:0] pre;
        logic [3:0] tick;
        logic [2:0][10:0] tcnt;
        logic [1:0][DW-1:0] dirCnt;
        logic [31:0] rdata;
        logic rdy;
        logic err;
    } state_s;

    state_s st_r;
    state_s st_nxt;
    logic on;
    logic acc;
    logic we;
    logic ovr;
    logic off;
    logic [1:0] dirRaw;
    logic [3:0] step;
    logic [2:0] hot;
    logic [2:0] conf;
    logic [2:0][ocp_pkg::MV_W-1:0] lim;
    ocp_pkg::status_s clr;
    ocp_pkg::status_s setv;
    ocp_pkg::event_s ev;
    ocp_pkg::event_s iclr;
    logic [31:0] rdat;
    logic err;

    assign on = (st_r.ctrl.mode != ocp_pkg::PWR_SLEEP) &&
                (st_r.ctrl.mode != ocp_pkg::PWR_DOWN); // [RL1]
    assign acc = psel && penable;
    // Writes land on the edge where pready is seen high
    assign we = acc && st_r.rdy && pwrite;
    assign ovr = st_r.ctrl.hostFetOverride;
    assign dirRaw = {inflow, outflow};
    assign step = {st_r.tick[2:0], 1'b1};

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        st_nxt = st_r;
        ev = '0;
        hot = '0;
        conf = '0;
        lim = '0;
        rdat = '0;
        err = 1'b0;
        off = 1'b0;
        clr = '0;
        iclr = '0;
        setv = '0;

        // Register writes
        if (we)
        begin
            if (paddr == ocp_pkg::A_CTRL)
                st_nxt.ctrl = ocp_pkg::ctrl_s'(pwdata[ocp_pkg::CTRL_W-1:0]);
            else if (paddr == ocp_pkg::A_THR)
                st_nxt.thr = ocp_pkg::thr_s'(pwdata[ocp_pkg::THR_W-1:0]);
            else if (paddr == ocp_pkg::A_DDIS)
                st_nxt.dly[0] = ocp_pkg::delay_s'(pwdata[ocp_pkg::DLY_W-1:0]);
            else if (paddr == ocp_pkg::A_DCHG)
                st_nxt.dly[1] = ocp_pkg::delay_s'(pwdata[ocp_pkg::DLY_W-1:0]);
            else if (paddr == ocp_pkg::A_DSHT)
                st_nxt.dly[2] = ocp_pkg::delay_s'(pwdata[ocp_pkg::DLY_W-1:0]);
            else if (paddr == ocp_pkg::A_CAL)
                st_nxt.cal = pwdata[ocp_pkg::CAL_W-1:0];
            else if (paddr == ocp_pkg::A_FCLR)
                clr = ocp_pkg::status_s'(pwdata[ocp_pkg::ST_W-1:0]);
            else if (paddr == ocp_pkg::A_ICLR)
                iclr = ocp_pkg::event_s'(pwdata[ocp_pkg::EV_W-1:0]);
            else if (paddr == ocp_pkg::A_IEN)
                st_nxt.ien = ocp_pkg::event_s'(pwdata[ocp_pkg::EV_W-1:0]);
        end

        // Time base: stage 0 steps every cycle, each higher stage on the tick of the one below
        st_nxt.tick = '0;
        for (int i = 0; i < 4; i++)
        begin
            if (step[i])
            begin
                if (st_r.pre[i] == PRE_LAST[i])
                begin
                    st_nxt.pre[i] = '0;
                    st_nxt.tick[i] = 1'b1;
                end
                else
                    st_nxt.pre[i] = st_r.pre[i] + 1'b1;
            end
        end

        // Direction filter, index 0 discharge, 1 charge
        for (int i = 0; i < 2; i++)
        begin
            if (!on)
            begin
                st_nxt.dir[i] = 1'b0; // [RL1]
                st_nxt.dirCnt[i] = '0;
            end
            else if (dirRaw[i] != st_r.dir[i])
            begin
                if (st_r.dirCnt[i] == DIR_LAST)
                begin
                    st_nxt.dir[i] = dirRaw[i]; // [RL5] [RL6]
                    st_nxt.dirCnt[i] = '0;
                    ev.dirChange = 1'b1;
                end
                else
                    st_nxt.dirCnt[i] = st_r.dirCnt[i] + 1'b1;
            end
            else
                st_nxt.dirCnt[i] = '0; // [RL5]
        end

        // Fault detectors: 0 discharge OC, 1 charge OC, 2 short circuit
        lim[0] = ocp_pkg::DIS_MV[st_r.thr.disOcThresholdCode]; // [RL7]
        lim[1] = ocp_pkg::CHG_MV[st_r.thr.chgOcThresholdCode]; // [RL8]
        lim[2] = ocp_pkg::SC_MV[st_r.thr.shortThresholdCode]; // [RL9]
        for (int i = 0; i < 3; i++)
        begin
            hot[i] = on && ((i == 1) ? inflow : outflow) && (senseMv > lim[i]);
            if (!hot[i])
                st_nxt.tcnt[i] = '0; // [RL17]
            // The first unit tick may come at once, so one extra tick is needed
            else if (st_r.tcnt[i] > {1'b0, st_r.dly[i].count})
                conf[i] = 1'b1; // [RL10]
            else if (st_r.tick[st_r.dly[i].scale])
                st_nxt.tcnt[i] = st_r.tcnt[i] + 1'b1; // [RL11]
        end

        // Flags: a set in the same cycle as a clear wins
        setv = {conf[1], conf[0] | conf[2], conf[2], conf[1], conf[0]};
        st_nxt.st = (st_r.st & ~clr) | setv; // [RL12] [RL14] [RL15] [RL18]
        ev.disTrip = conf[0] && !st_r.st.disOvercurrentFlag;
        ev.chgTrip = conf[1] && !st_r.st.chgOvercurrentFlag;
        ev.shortTrip = conf[2] && !st_r.st.shortCircuitFlag;

        // FET drive; the automatic trip lasts while an OC flag stands
        st_nxt.autoOff = ((conf[0] || conf[1]) && !ovr) ||
                         (st_r.autoOff && (st_nxt.st.disOvercurrentFlag ||
                                           st_nxt.st.chgOvercurrentFlag)); // [RL13]
        off = st_nxt.st.shortCircuitFlag || st_nxt.autoOff; // [RL16]
        st_nxt.fetC = !off && (!ovr || st_r.ctrl.hostChgFet); // [RL13]
        st_nxt.fetD = !off && (!ovr || st_r.ctrl.hostDisFet);

        // Conversion store; wraps at 14 bits if the offset overshoots
        if (adcValid && on)
        begin
            st_nxt.cur = adcRaw - st_r.cal; // [RL3] [RL4]
            st_nxt.cmp = st_nxt.cur[ocp_pkg::CAL_W-1:ocp_pkg::CMP_LSB]; // [RL3]
            ev.convDone = 1'b1;
        end

        // Reserved gain code falls back to the widest span
        if (st_r.ctrl.currentGainSel == ocp_pkg::GAIN_RSVD)
            st_nxt.gain = ocp_pkg::GAIN_X5; // [RL2]
        else
            st_nxt.gain = st_r.ctrl.currentGainSel; // [RL2]

        // Interrupts
        st_nxt.ist = (st_r.ist & ~iclr) | ev;
        st_nxt.irq = |(st_nxt.ist & st_nxt.ien);

        // Read decode
        if (paddr == ocp_pkg::A_CTRL)
            rdat = 32'(st_r.ctrl);
        else if (paddr == ocp_pkg::A_THR)
            rdat = 32'(st_r.thr);
        else if (paddr == ocp_pkg::A_DDIS)
            rdat = 32'(st_r.dly[0]);
        else if (paddr == ocp_pkg::A_DCHG)
            rdat = 32'(st_r.dly[1]);
        else if (paddr == ocp_pkg::A_DSHT)
            rdat = 32'(st_r.dly[2]);
        else if (paddr == ocp_pkg::A_CAL)
            rdat = 32'(st_r.cal);
        else if (paddr == ocp_pkg::A_CUR)
            rdat = 32'({st_r.cmp, 2'h0, st_r.cur});
        else if (paddr == ocp_pkg::A_STAT)
            rdat = 32'({st_r.fetD, st_r.fetC, st_r.dir, st_r.st});
        else if (paddr == ocp_pkg::A_ISTAT)
            rdat = 32'(st_r.ist);
        else if (paddr == ocp_pkg::A_IEN)
            rdat = 32'(st_r.ien);
        else if (paddr == ocp_pkg::A_FCLR || paddr == ocp_pkg::A_ICLR)
            rdat = '0;
        else
            err = 1'b1;

        // One wait state gives registered read data
        st_nxt.rdy = acc && !st_r.rdy;
        st_nxt.rdata = st_nxt.rdy ? rdat : '0;
        st_nxt.err = st_nxt.rdy && err;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign prdata = st_r.rdata;
    assign pready = st_r.rdy;
    assign pslverr = st_r.err;
    assign ampGain = st_r.gain;
    assign chgFetOn = st_r.fetC;
    assign disFetOn = st_r.fetD;
    assign irq = st_r.irq;

    ////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence autoTrip_q;
        (conf[0] || conf[1]) && !ovr;
    endsequence
    sequence fetsOff_q;
        !chgFetOn && !disFetOn;
    endsequence
    property tripOff_p;
        autoTrip_q |=> fetsOff_q;
    endproperty

    sleep_idle_a: assert property (!on |=> st_r.dir == 2'h0 && st_r.tcnt == '0) // [RL1]
        else $error("monitor active in sleep");

    gain_map_a: assert property ((st_r.ctrl.currentGainSel != ocp_pkg::GAIN_RSVD) // [RL2]
        |=> ampGain == $past(st_r.ctrl.currentGainSel))
        else $error("gain output wrong");

    cmp_scale_a: assert property ((adcValid && on) // [RL3]
        |=> st_r.cmp == 12'(14'($past(adcRaw) - $past(st_r.cal)) >> ocp_pkg::CMP_LSB))
        else $error("compare value mismatch");

    offset_a: assert property ((adcValid && on) // [RL4]
        |=> st_r.cur == 14'($past(adcRaw) - $past(st_r.cal)))
        else $error("offset correction wrong");

    dir_filter_a: assert property ($changed(st_r.dir[0]) && $past(on) // [RL5]
        |-> $past(st_r.dirCnt[0]) == DIR_LAST)
        else $error("direction changed early");

    dir_flag_a: assert property ($rose(st_r.dir[1]) |-> $past(inflow)) // [RL6]
        else $error("charge direction without inflow");

    thr_dis_a: assert property (conf[0] // [RL7]
        |-> senseMv > ocp_pkg::DIS_MV[st_r.thr.disOcThresholdCode])
        else $error("discharge trip below threshold");

    thr_chg_a: assert property (conf[1] // [RL8]
        |-> senseMv > ocp_pkg::CHG_MV[st_r.thr.chgOcThresholdCode])
        else $error("charge trip below threshold");

    thr_short_a: assert property (conf[2] // [RL9]
        |-> senseMv > ocp_pkg::SC_MV[st_r.thr.shortThresholdCode])
        else $error("short trip below threshold");

    delay_done_a: assert property (conf[2] // [RL10]
        |-> st_r.tcnt[2] > {1'b0, st_r.dly[2].count})
        else $error("short declared before delay");

    unit_step_a: assert property ((hot[0] && !conf[0] && // [RL11]
        !st_r.tick[st_r.dly[0].scale]) |=> $stable(st_r.tcnt[0]))
        else $error("delay stepped off its unit");

    dis_flag_a: assert property (conf[0] // [RL12]
        |=> st_r.st.disOvercurrentFlag && st_r.st.loadPresentFlag)
        else $error("discharge flags not set");

    oc_fet_off_a: assert property (tripOff_p) // [RL13]
        else $error("FETs on after overcurrent");

    chg_flag_a: assert property (conf[1] // [RL14]
        |=> st_r.st.chgOvercurrentFlag && st_r.st.chargerPresentFlag)
        else $error("charge flags not set");

    short_flag_a: assert property (conf[2] // [RL15]
        |=> st_r.st.shortCircuitFlag && st_r.st.loadPresentFlag)
        else $error("short flags not set");

    short_fet_off_a: assert property (st_r.st.shortCircuitFlag |-> fetsOff_q) // [RL16]
        else $error("FETs on during short");

    restart_a: assert property (!hot[1] |=> st_r.tcnt[1] == '0) // [RL17]
        else $error("delay not restarted");

    flag_hold_a: assert property ($fell(st_r.st.disOvercurrentFlag) // [RL18]
        |-> $past(we && paddr == ocp_pkg::A_FCLR))
        else $error("fault flag dropped by itself");

    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
endmodule
